/* File: rtl/nbc_regs.vh */
// Register map, field layout, reset values and opcodes of the nibble core.
// Assumes inclusion by bare name from the core module.
`ifndef NBC_REGS_VH
`define NBC_REGS_VH

// Register word indexes; byte address is four times the index
`define NBC_IDX_INSTR   6'h00
`define NBC_IDX_ACC     6'h01
`define NBC_IDX_PTR     6'h02
`define NBC_IDX_PC      6'h03
`define NBC_IDX_RAM     6'h04
`define NBC_IDX_PORTD   6'h05
`define NBC_IDX_TIMER2  6'h06
`define NBC_IDX_FLAGS   6'h07
`define NBC_IDX_STACK   6'h08
`define NBC_NUM_REGS    6'h09

// Field positions
`define NBC_ACC_CARRY   4
`define NBC_FLG_TMR1    0
`define NBC_FLG_TMR2    1
`define NBC_FLG_BOOL_LSB 2
`define NBC_FLG_CLKSEL  4
`define NBC_PC_SP_LSB   11

// Reset values
`define NBC_RST_PC      11'h000
`define NBC_RST_NIB     4'h0
`define NBC_RST_BYTE    8'h00
`define NBC_RST_LO      2'h0

// AXI responses
`define NBC_RESP_OKAY   2'h0
`define NBC_RESP_SLVERR 2'h2

// Opcodes (9-bit instruction words), 5-bit opcode prefixes and the short-call page
`define NBC_OP_BA       9'h001
`define NBC_OP_ADD_CARRY  9'h00B
`define NBC_OP_ROW_INC    9'h013
`define NBC_OP_ROW_DEC    9'h017
`define NBC_OP_PORT_TEST1 9'h024
`define NBC_OP_PORT_TEST2 9'h02B
`define NBC_OP_T1TEST   9'h042
`define NBC_OP_CALL_IDX   9'h050
`define NBC_OP_T2TEST   9'h052
`define NBC_OP_CLK_FULL   9'h059
`define NBC_OP_T2COPY   9'h09A
`define NBC_OP_SETLO    9'h09B
`define NBC_PFX_CALL_FAR  5'h07
`define NBC_PFX_ADDI    5'h0A
`define NBC_PAGE_TWO    4'h2

`endif

/* File: rtl/nbc_rstack.v */
// Four-entry return stack of 11-bit program counter values.
// Assumes a one-cycle push strobe from the core on the same clock.
`timescale 1ns/100ps
module nbc_rstack
#(
  parameter DEPTH_W = 2,
  parameter PC_W    = 11
)
(
  input  wire                aclk,
  input  wire                aresetn,
  input  wire                push,
  input  wire [PC_W-1:0]     push_data,
  output reg  [DEPTH_W-1:0]  stack_pointer,
  output wire [PC_W-1:0]     top
);
  reg     [PC_W-1:0] return_stack [0:(1<<DEPTH_W)-1];
  wire    [DEPTH_W-1:0] next_sp;
  integer i;

  assign next_sp = stack_pointer + {{(DEPTH_W-1){1'b0}}, 1'b1};
  assign top     = return_stack[stack_pointer];

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stack_pointer <= {DEPTH_W{1'b0}};
      for (i = 0; i < (1<<DEPTH_W); i = i + 1)
        return_stack[i] <= {PC_W{1'b0}};
    end
    else if (push)
    begin
      // Pointer and the entry at its new value are written on the same edge
      stack_pointer          <= next_sp;
      return_stack[next_sp]  <= push_data;
    end
  end
endmodule

/* File: rtl/nbc_core.v */
// Nibble core: executes branch, call, timer-flag, row-pointer and logic-select
// instructions written one word at a time over an AXI4-Lite slave.
// Assumes timer underflow pulses come from logic on aclk.
//
// Notes on behaviour
// - Add immediate adds 0..15 to A, keeps carry, skips on no overflow.
// - Indexed in-page jump takes upper three address bits with A as low four.
// - Short call pushes PC, bumps pointer, page becomes 2, low address immediate.
// - Far call pushes PC, bumps pointer, jumps to 7-bit address in page 0..15.
// - Indexed far call pushes PC, bumps pointer, page from second word's low four bits, then its bits 6..4, A as low four.
// - Clock switch moves system clock from oscillator/8 to undivided oscillator.
// - Row decrement subtracts one, skips when result wraps to 15.
// - Row increment adds one, skips when result wraps to 0.
// - Timer 1 flag test skips when flag set and clears the flag.
// - Timer 2 flag test skips when flag set and clears the flag.
// - Timer 2 reload copy loads counter nibbles from the low reload register.
// - Port bit test skips when D(row) is zero; valid for rows 4..7.
// - Logic select load copies A's two low bits into the selector.
// - A skip suppresses the next instruction but still spends its cycles.
// - Return stack holds four 11-bit entries indexed by a 2-bit pointer.
//
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`include "nbc_regs.vh"
module nbc_core
#(
  parameter [8:0] OP_T2COPY = `NBC_OP_T2COPY,
  parameter [8:0] OP_SETLO  = `NBC_OP_SETLO
)
(
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        timer1_underflow,
  input  wire        timer2_underflow,
  output reg         system_clock_select,
  output reg  [1:0]  boolean_op_select,
  output reg  [7:0]  port_d_out,
  output reg  [7:0]  timer2_count
);
  reg  [7:0]  aw_addr_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  reg  [3:0]  acc;
  reg         carry_flag;
  reg  [1:0]  row_x;
  reg  [3:0]  row_y;
  reg  [10:0] program_counter;
  reg  [7:0]  timer2_low_reload;
  reg         timer1_underflow_flag;
  reg         timer2_underflow_flag;
  reg         skip;
  reg         pend;
  reg         pend_skip;
  reg  [8:0]  pend_op;
  reg  [3:0]  ram [0:63];
  wire [1:0]  stack_pointer;
  wire [10:0] stack_top;
  wire [5:0]  data_pointer;
  wire [3:0]  ram_dp;
  wire [5:0]  wr_idx;
  wire [5:0]  rd_idx;
  wire        wr_go;
  wire [8:0]  word;
  wire        ex_first;
  wire        ex_second;
  wire        push;
  wire [10:0] pc_inc;
  wire [4:0]  add_imm;
  wire [4:0]  add_mem;
  wire [287:0] reg_bus;
  wire [31:0] cur_w;
  wire [31:0] cur_r;
  wire [31:0] wm;
  integer     i;

  // Register index lies inside the map
  function mapped;
    input [5:0] idx;
    begin
      mapped = (idx < `NBC_NUM_REGS);
    end
  endfunction

  // First word of an instruction that takes a second word
  function is_two;
    input [8:0] w;
    begin
      is_two = (w == `NBC_OP_BA) || (w == `NBC_OP_CALL_IDX) || (w == `NBC_OP_PORT_TEST1) ||
               (w[8:4] == `NBC_PFX_CALL_FAR);
    end
  endfunction

  // Byte-lane merge of a write into the current register word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] new_data;
    input [3:0]  strb;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1)
        if (strb[k])
          merge[8*k +: 8] = new_data[8*k +: 8];
    end
  endfunction

  assign data_pointer = {row_x, row_y};
  assign ram_dp       = ram[data_pointer];
  assign wr_idx       = aw_addr_q[7:2];
  assign rd_idx       = s_axi_araddr[7:2];
  assign wr_go        = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign word         = w_data_q[8:0];
  assign ex_first     = wr_go && (wr_idx == `NBC_IDX_INSTR) && (w_strb_q != 4'h0) && !pend;
  assign ex_second    = wr_go && (wr_idx == `NBC_IDX_INSTR) && (w_strb_q != 4'h0) && pend;
  assign pc_inc       = program_counter + 11'h001;
  assign add_imm      = {1'b0, acc} + {1'b0, word[3:0]};
  assign add_mem      = {1'b0, acc} + {1'b0, ram_dp} + {4'h0, carry_flag};
  assign push         = (ex_first && !skip && (word[8:7] == 2'b10)) ||
                        (ex_second && !pend_skip && ((pend_op == `NBC_OP_CALL_IDX) ||
                         (pend_op[8:4] == `NBC_PFX_CALL_FAR)));

  assign reg_bus = {
    {21'h0, stack_top},
    {27'h0, system_clock_select, boolean_op_select, timer2_underflow_flag, timer1_underflow_flag},
    {16'h0, timer2_low_reload, timer2_count},
    {24'h0, port_d_out},
    {28'h0, ram_dp},
    {19'h0, stack_pointer, program_counter},
    {26'h0, row_x, row_y},
    {27'h0, carry_flag, acc},
    {30'h0, pend, skip}};
  assign cur_w = mapped(wr_idx) ? reg_bus[wr_idx*32 +: 32] : 32'h0000_0000;
  assign cur_r = mapped(rd_idx) ? reg_bus[rd_idx*32 +: 32] : 32'h0000_0000;
  assign wm    = merge(cur_w, w_data_q, w_strb_q);

  nbc_rstack #(
    .DEPTH_W (2),
    .PC_W    (11)
  ) u_stack (
    .aclk          (aclk),
    .aresetn       (aresetn),
    .push          (push),
    .push_data     (pc_inc),
    .stack_pointer (stack_pointer),
    .top           (stack_top)
  );

  // AXI4-Lite handshakes: one write and one read in flight
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `NBC_RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `NBC_RESP_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_addr_q     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data_q     <= s_axi_wdata;
        w_strb_q     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(wr_idx) ? `NBC_RESP_OKAY : `NBC_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= cur_r;
        s_axi_rresp   <= mapped(rd_idx) ? `NBC_RESP_OKAY : `NBC_RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Core state: register writes and instruction execution
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      acc                   <= `NBC_RST_NIB;
      carry_flag            <= 1'b0;
      row_x                 <= 2'h0;
      row_y                 <= `NBC_RST_NIB;
      program_counter       <= `NBC_RST_PC;
      port_d_out            <= `NBC_RST_BYTE;
      timer2_count          <= `NBC_RST_BYTE;
      timer2_low_reload     <= `NBC_RST_BYTE;
      timer1_underflow_flag <= 1'b0;
      timer2_underflow_flag <= 1'b0;
      system_clock_select   <= 1'b0;
      boolean_op_select     <= `NBC_RST_LO;
      skip                  <= 1'b0;
      pend                  <= 1'b0;
      pend_skip             <= 1'b0;
      pend_op               <= 9'h000;
      for (i = 0; i < 64; i = i + 1)
        ram[i] <= `NBC_RST_NIB;
    end
    else
    begin
      // Underflow sets the flag; a set in the clearing cycle wins
      timer1_underflow_flag <= timer1_underflow_flag | timer1_underflow;
      timer2_underflow_flag <= timer2_underflow_flag | timer2_underflow;
      if (wr_go)
      begin
        case (wr_idx)
          `NBC_IDX_ACC:
          begin
            acc        <= wm[3:0];
            carry_flag <= wm[`NBC_ACC_CARRY];
          end
          `NBC_IDX_PTR:
          begin
            row_y <= wm[3:0];
            row_x <= wm[5:4];
          end
          `NBC_IDX_PC:
            program_counter <= wm[10:0];
          `NBC_IDX_RAM:
            ram[w_data_q[9:4]] <= w_data_q[3:0];
          `NBC_IDX_PORTD:
            port_d_out <= wm[7:0];
          `NBC_IDX_TIMER2:
          begin
            timer2_count      <= wm[7:0];
            timer2_low_reload <= wm[15:8];
          end
          default:
          begin
          end
        endcase
      end
      if (ex_second)
      begin
        // Second word: one more cycle for the two-word instruction
        pend            <= 1'b0;
        program_counter <= pc_inc;
        skip            <= 1'b0;
        if (!pend_skip)
        begin
          if (pend_op == `NBC_OP_BA)
            program_counter <= {program_counter[10:7], word[6:4], acc};
          else if (pend_op[8:4] == `NBC_PFX_CALL_FAR)
            program_counter <= {pend_op[3:0], word[6:0]};
          else if (pend_op == `NBC_OP_CALL_IDX)
            program_counter <= {word[3:0], word[6:4], acc};
          else if (pend_op == `NBC_OP_PORT_TEST1)
            skip <= row_y[3:2] == 2'b01 && !port_d_out[row_y[2:0]];
        end
      end
      else if (ex_first)
      begin
        program_counter <= pc_inc;
        skip            <= 1'b0;
        if (is_two(word))
        begin
          pend      <= 1'b1;
          pend_op   <= word;
          pend_skip <= skip;
        end
        else if (!skip)
        begin
          if (word[8:4] == `NBC_PFX_ADDI)
          begin
            acc  <= add_imm[3:0];
            skip <= !add_imm[4];
          end
          else if (word[8:7] == 2'b11)
            program_counter <= {program_counter[10:7], word[6:0]};
          else if (word[8:7] == 2'b10)
            program_counter <= {`NBC_PAGE_TWO, word[6:0]};
          else
          begin
            case (word)
              `NBC_OP_ADD_CARRY:
              begin
                acc        <= add_mem[3:0];
                carry_flag <= add_mem[4];
              end
              `NBC_OP_CLK_FULL:
                system_clock_select <= 1'b1;
              `NBC_OP_ROW_DEC:
              begin
                row_y <= row_y - 4'h1;
                skip  <= (row_y == 4'h0);
              end
              `NBC_OP_ROW_INC:
              begin
                row_y <= row_y + 4'h1;
                skip  <= (row_y == 4'hF);
              end
              `NBC_OP_T1TEST:
              begin
                skip                  <= timer1_underflow_flag;
                timer1_underflow_flag <= timer1_underflow;
              end
              `NBC_OP_T2TEST:
              begin
                skip                  <= timer2_underflow_flag;
                timer2_underflow_flag <= timer2_underflow;
              end
              OP_T2COPY:
                timer2_count <= timer2_low_reload;
              OP_SETLO:
                boolean_op_select <= acc[1:0];
              default:
              begin
              end
            endcase
          end
        end
      end
    end
  end
endmodule

/* File: bench/nbc_monitor.sv */
// Checker for the nibble core: bus timing and output causes.
// Assumes binding to nbc_core; sees its ports only.
`timescale 1ns/100ps
module nbc_monitor (
  input wire       aclk,
  input wire       aresetn,
  input wire       s_axi_awvalid,
  input wire       s_axi_awready,
  input wire       s_axi_wvalid,
  input wire       s_axi_wready,
  input wire       s_axi_bvalid,
  input wire       s_axi_bready,
  input wire       s_axi_arvalid,
  input wire       s_axi_arready,
  input wire       s_axi_rvalid,
  input wire       s_axi_rready,
  input wire       system_clock_select,
  input wire [1:0] boolean_op_select,
  input wire [7:0] timer2_count
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wr_done;
    s_axi_bvalid && s_axi_bready;
  endsequence

  wr_answer_a: assert property (wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer late");
  wr_release_a: assert property (wr_done |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write not released");
  wr_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  rd_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read not released");
  clk_sticky_a: assert property (system_clock_select |=> system_clock_select)
    else $error("clock select fell");
  clk_cause_a: assert property ($rose(system_clock_select) |-> $rose(s_axi_bvalid))
    else $error("clock select moved alone");
  lo_cause_a: assert property ($changed(boolean_op_select) |-> $rose(s_axi_bvalid))
    else $error("logic select moved alone");
  t2_cause_a: assert property ($changed(timer2_count) |-> $rose(s_axi_bvalid))
    else $error("timer2 count moved alone");
endmodule

bind nbc_core nbc_monitor u_mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .system_clock_select, .boolean_op_select, .timer2_count);

/* File: bench/nibble_cpu_branch_timer_ops_test.sv */
// Bench for the nibble core: instructions and registers over AXI4-Lite.
// Assumes nbc_core with default opcode parameters.
`timescale 1ns/100ps
`define CK(n, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module nibble_cpu_branch_timer_ops_test;
  reg         aclk;
  reg         aresetn;
  reg  [7:0]  awaddr;
  reg         awvalid;
  reg  [31:0] wdata;
  reg         wvalid;
  reg         bready;
  reg  [7:0]  araddr;
  reg         arvalid;
  reg         rready;
  reg         t1u;
  reg         t2u;
  wire        awready;
  wire        wready;
  wire [1:0]  bresp;
  wire        bvalid;
  wire        arready;
  wire [31:0] rdata;
  wire [1:0]  rresp;
  wire        rvalid;
  wire        clk_sel;
  wire [1:0]  lo_sel;
  wire [7:0]  t2c;
  wire [7:0]  pd;
  reg  [31:0] rv;
  reg  [1:0]  rs;
  integer     n_errors;
  integer     n_compared;
  integer     i;

  nbc_core u_dut (
    .aclk                (aclk),
    .aresetn             (aresetn),
    .s_axi_awaddr        (awaddr),
    .s_axi_awprot        (3'h0),
    .s_axi_awvalid       (awvalid),
    .s_axi_awready       (awready),
    .s_axi_wdata         (wdata),
    .s_axi_wstrb         (4'hf),
    .s_axi_wvalid        (wvalid),
    .s_axi_wready        (wready),
    .s_axi_bresp         (bresp),
    .s_axi_bvalid        (bvalid),
    .s_axi_bready        (bready),
    .s_axi_araddr        (araddr),
    .s_axi_arprot        (3'h0),
    .s_axi_arvalid       (arvalid),
    .s_axi_arready       (arready),
    .s_axi_rdata         (rdata),
    .s_axi_rresp         (rresp),
    .s_axi_rvalid        (rvalid),
    .s_axi_rready        (rready),
    .timer1_underflow    (t1u),
    .timer2_underflow    (t2u),
    .system_clock_select (clk_sel),
    .boolean_op_select   (lo_sel),
    .port_d_out          (pd),
    .timer2_count        (t2c)
  );

  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task close_out;
    begin
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  task wr(input [7:0] a, input [15:0] d);
    integer n;
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= {16'h0000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      while (!bvalid && n < 40)
      begin
        @(posedge aclk);
        n = n + 1;
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      rs = bresp;
      if (n >= 40) begin n_errors++; close_out; end
    end
  endtask

  task rd(input [7:0] a);
    integer n;
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      while (!rvalid && n < 40)
      begin
        @(posedge aclk);
        n = n + 1;
        if (arready) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      rv = rdata;
      rs = rresp;
      if (n >= 40) begin n_errors++; close_out; end
    end
  endtask

  task x(input [8:0] w);
    wr(8'h00, {7'h00, w});
  endtask

  task ck(input [7:0] a, input [15:0] e, input [63:0] nm);
    begin
      rd(a);
      `CK(nm, {16'h0000, e}, rv)
    end
  endtask

  task t_add;
    begin
      wr(8'h04, 16'h001e);
      x(9'h0a3);
      ck(8'h04, 16'h0011, "acc");
      ck(8'h00, 16'h0000, "skip");
      x(9'h0a1);
      ck(8'h00, 16'h0001, "skip");
      x(9'h013);
      ck(8'h08, 16'h0000, "ptr");
      wr(8'h10, 16'h0059);
      wr(8'h08, 16'h0005);
      wr(8'h04, 16'h0018);
      x(9'h00b);
      ck(8'h04, 16'h0012, "acc");
      $display("add end");
    end
  endtask

  task t_call;
    begin
      wr(8'h0c, 16'h0123);
      wr(8'h04, 16'h0005);
      x(9'h001);
      ck(8'h00, 16'h0002, "pend");
      x(9'h1ff);
      ck(8'h0c, 16'h0175, "pc");
      wr(8'h0c, 16'h0010);
      x(9'h133);
      ck(8'h0c, 16'h0933, "pc");
      ck(8'h20, 16'h0011, "stk");
      x(9'h07a);
      x(9'h145);
      ck(8'h0c, 16'h1545, "pc");
      ck(8'h20, 16'h0135, "stk");
      wr(8'h04, 16'h000c);
      x(9'h050);
      x(9'h136);
      ck(8'h0c, 16'h1b3c, "pc");
      ck(8'h20, 16'h0547, "stk");
      x(9'h100);
      ck(8'h0c, 16'h0100, "pc");
      ck(8'h20, 16'h033d, "stk");
      $display("call end");
    end
  endtask

  task t_row;
    begin
      wr(8'h08, 16'h0000);
      x(9'h017);
      ck(8'h08, 16'h000f, "ptr");
      ck(8'h00, 16'h0001, "skip");
      x(9'h013);
      x(9'h013);
      ck(8'h08, 16'h0000, "ptr");
      ck(8'h00, 16'h0001, "skip");
      x(9'h017);
      ck(8'h08, 16'h0000, "ptr");
      x(9'h013);
      ck(8'h00, 16'h0000, "skip");
      $display("row end");
    end
  endtask

  task t_tmr;
    begin
      @(posedge aclk);
      t1u <= 1'b1;
      t2u <= 1'b1;
      @(posedge aclk);
      t1u <= 1'b0;
      t2u <= 1'b0;
      x(9'h042);
      ck(8'h1c, 16'h0002, "flg");
      ck(8'h00, 16'h0001, "skip");
      x(9'h052);
      x(9'h052);
      ck(8'h1c, 16'h0000, "flg");
      ck(8'h00, 16'h0001, "skip");
      x(9'h042);
      ck(8'h00, 16'h0000, "skip");
      wr(8'h18, 16'h5a3c);
      x(9'h09a);
      `CK("t2c", 8'h5a, t2c)
      ck(8'h18, 16'h5a5a, "t2");
      $display("timer end");
    end
  endtask

  task t_misc;
    begin
      wr(8'h14, 16'h0020);
      `CK("portd", 8'h20, pd)
      for (i = 3; i < 9; i = i + 1)
      begin
        wr(8'h08, i[15:0]);
        x(9'h024);
        x(9'h02b);
        ck(8'h00, {15'h0000, i > 3 && i < 8 && i != 5}, "szd");
        x(9'h000);
      end
      for (i = 0; i < 4; i = i + 1)
      begin
        wr(8'h04, 16'h001c + i[15:0]);
        x(9'h09b);
        `CK("lo", i[1:0], lo_sel)
      end
      `CK("clk", 1'b0, clk_sel)
      wr(8'h0c, 16'h0000);
      x(9'h059);
      `CK("clk", 1'b1, clk_sel)
      ck(8'h1c, 16'h001c, "flg");
      wr(8'h24, 16'h00ff);
      `CK("bresp", 2'h2, rs)
      rd(8'h24);
      `CK("rresp", 2'h2, rs)
      `CK("rdata", 32'h0000_0000, rv)
      $display("misc end");
    end
  endtask

  initial
  begin
    aresetn = 1'b0;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0000_0000;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    t1u = 1'b0;
    t2u = 1'b0;
    n_errors = 0;
    n_compared = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_add;
    t_call;
    t_row;
    t_tmr;
    t_misc;
    close_out;
  end

  initial
  begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    close_out;
  end
endmodule
